// ===== dv/scpc_dev_model.sv
// behavioural device: byte registers behind spi and two-wire slave ports
// assumes the bench resolves the pins; the clock line is only observed
`timescale 1ns/1ps
module scpc_dev_model (
	// spi pins
	input wire logic i_sclk,
	input wire logic i_cs_b,
	input wire logic i_mosi,
	output logic o_miso,
	// two-wire pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_pull,
	// strap levels
	input wire logic [2:0] i_strap
);
	logic [7:0] mem [0:8191];
	logic [15:0] iw, ptr;
	logic [7:0] db, sr, tx;
	logic [12:0] a;
	logic lsb = 0, lsbn = 0, rd = 0, act = 0;
	int sc = 0, cnt = 0, n = 0;
	// spikes under 50 ns never reach the slave logic
	wire #50 scl_f = i_scl;
	wire #50 sda_f = i_sda;
	initial begin
		o_miso = 0;
		o_sda_pull = 0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	// new order from the next frame; released line flips
	always @(posedge i_cs_b) begin
		lsb = lsbn;
		o_miso = ~o_miso;
	end
	always @(negedge i_cs_b) sc = 0;
	always @(posedge i_sclk) if (!i_cs_b && i_strap == 3'h0) begin
		if (sc < 16) iw = lsb ? {i_mosi, iw[15:1]} : {iw[14:0], i_mosi};
		else if (!iw[15]) begin
			db = lsb ? {i_mosi, db[7:1]} : {db[6:0], i_mosi};
			if (sc % 8 == 7) begin
				mem[a] = db;
				if (a == 13'h0) lsbn = db[6];
				a = lsb ? a + 13'h1 : a - 13'h1;
			end
		end
		sc++;
		if (sc == 16) a = iw[12:0];
	end
	always @(negedge i_sclk) if (!i_cs_b && iw[15] && sc >= 16) begin
		if (sc % 8 == 0) begin
			db = mem[a];
			a = lsb ? a + 13'h1 : a - 13'h1;
		end
		o_miso = lsb ? db[sc % 8] : db[7 - sc % 8];
	end
	always @(negedge sda_f) if (scl_f) begin
		cnt = 0;
		n = 0;
	end
	always @(posedge sda_f) if (scl_f) begin
		cnt = 0;
		n = 0;
		act = 0;
	end
	always @(posedge scl_f) begin
		if (cnt < 8) sr = {sr[6:0], sda_f};
		else if (rd && sda_f) act = 0;
		cnt++;
	end
	// changes data only while the clock line is low, never the clock
	always @(negedge scl_f) begin
		o_sda_pull = 0;
		if (cnt == 8) begin
			if (n == 0) begin
				act = sr[7:1] == {4'h9, i_strap} && i_strap != 3'h0;
				rd = sr[0];
			end else if (!rd && n < 3) ptr = {ptr[7:0], sr};
			else if (!rd) begin
				mem[ptr[12:0]] = sr;
				ptr++;
			end
			o_sda_pull = act && (n == 0 || !rd);
			n++;
		end else if (cnt == 9) begin
			cnt = 0;
			if (rd && act) begin
				tx = mem[ptr[12:0]];
				ptr++;
			end
		end
		if (rd && act && cnt < 8) o_sda_pull = ~tx[7 - cnt];
	end
endmodule

// ===== dv/test_scpc_host.sv
// self-checking bench for the serial control port host
// assumes the device model on the pins and avalon-mm access from here
`timescale 1ns/1ps
module test_scpc_host;
	import scpc_pkg::*;
	logic i_core_clk = 0, i_rst_b = 0, i_avs_read = 0, i_avs_write = 0;
	logic [4:0] i_avs_address = 5'h00;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, r, m;
	logic o_avs_waitrequest, o_sclk, o_cs_b, o_sdio, o_sdio_oe, miso;
	logic o_scl, o_scl_oe, o_sda, o_sda_oe, sda_pull, bad = 0, uni = 0;
	logic [2:0] o_port_select_pins;
	wire sda = ~(o_sda_oe | sda_pull);
	wire scl = ~o_scl_oe;
	// the data pin not in use for reads shows the inverse
	wire sdio = o_sdio_oe ? o_sdio : uni ? ~miso : miso;
	wire serial_out_line = uni ? miso : ~miso;
	int miscompares = 0, n_compared = 0;
	scpc_host scpc_host_inst (.i_core_clk, .i_rst_b, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
		.o_avs_waitrequest, .o_sclk, .o_cs_b, .i_sdio(sdio), .o_sdio,
		.o_sdio_oe, .i_serial_out_line(serial_out_line), .o_scl, .o_scl_oe,
		.i_sda(sda), .o_sda, .o_sda_oe, .o_port_select_pins);
	scpc_dev_model scpc_dev_model_inst (.i_sclk(o_sclk), .i_cs_b(o_cs_b),
		.i_mosi(o_sdio), .o_miso(miso), .i_scl(scl), .i_sda(sda),
		.o_sda_pull(sda_pull),
		.i_strap(bad ? 3'h6 : o_port_select_pins));
	initial forever #2 i_core_clk = ~i_core_clk;
	function automatic logic [7:0] mb(int a);
		return scpc_dev_model_inst.mem[a];
	endfunction
	function automatic logic [31:0] cw(int rd, int two, int w4, int c);
		return 32'(1 + (rd << CTL_RD) + (two << CTL_I2C) +
			(two << CTL_FAST) + (w4 << CTL_4W) + (c << CTL_CNT));
	endfunction
	task automatic bus(input logic wr, input logic [4:0] ad,
		input logic [31:0] wd);
		int t;
		t = 0;
		i_avs_address <= ad;
		i_avs_writedata <= wd;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do begin
			@(posedge i_core_clk);
			t++;
		end while (o_avs_waitrequest !== 1'b0 && t < 50);
		r = o_avs_readdata;
		i_avs_write <= 0;
		i_avs_read <= 0;
		if (t >= 50) begin
			miscompares++;
			$display("Error %0t: bus answer missing", $time);
		end
		@(posedge i_core_clk);
	endtask
	task automatic chk(input logic [31:0] got, want);
		n_compared++;
		if (got !== want) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic run(input logic [31:0] ctl);
		int t;
		bus(1, OFS_CTRL, ctl);
		t = 0;
		do begin
			bus(0, OFS_STAT, 0);
			t++;
		end while (r[0] !== 1'b0 && t < 20000);
		if (t >= 20000) begin
			miscompares++;
			$display("Error %0t: transfer never ended", $time);
		end
	endtask
	task automatic test_done;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst_b <= 1;
		@(posedge i_core_clk);
		chk(o_cs_b, 1);
		bus(0, OFS_STAT, 0);
		chk(r, 0);
		bus(0, 5'h18, 0);
		chk(r, 0);
		$display("done reset");
		bus(1, OFS_ADDR, 32'h0105);
		bus(1, OFS_WDATA, 32'ha53c);
		run(cw(0, 0, 0, 1));
		chk(scpc_dev_model_inst.iw, 32'h2105);
		chk(mb(261), 8'h3c);
		chk(mb(260), 8'ha5);
		for (int c = 0; c < 4; c++) begin
			uni = c[0];
			run(cw(1, 0, c % 2, c));
			chk(scpc_dev_model_inst.iw[14:13], c);
			bus(0, OFS_RDATA, 0);
			m = ~(32'hffffffff << 8 * (c + 1));
			chk(r & m, 32'ha53c & m);
		end
		uni = 0;
		$display("done spi msb first");
		bus(1, OFS_ADDR, 0);
		bus(1, OFS_WDATA, 32'h40);
		run(cw(0, 0, 0, 0));
		bus(0, OFS_STAT, 0);
		chk(r[2], 1);
		bus(1, OFS_ADDR, 32'h0200);
		bus(1, OFS_WDATA, 32'h2211);
		run(cw(0, 0, 0, 1));
		chk(scpc_dev_model_inst.iw, 32'h2200);
		chk({mb(513), mb(512)}, 32'h2211);
		run(cw(1, 0, 0, 1));
		bus(0, OFS_RDATA, 0);
		chk(r[15:0], 32'h2211);
		$display("done spi lsb first");
		bus(1, OFS_PINS, 32'h5);
		bus(0, OFS_PINS, 0);
		chk(r, 32'h5);
		chk(o_port_select_pins, 3'h5);
		bus(1, OFS_ADDR, 32'h0300);
		bus(1, OFS_WDATA, 32'hbeef);
		run(cw(0, 1, 0, 1));
		chk(r[1], 0);
		chk({mb(769), mb(768)}, 32'hbeef);
		run(cw(1, 1, 0, 0));
		bus(0, OFS_RDATA, 0);
		chk(r[7:0], 32'hef);
		bad = 1;
		run(cw(0, 1, 0, 0) & ~(32'h1 << CTL_FAST));
		chk(r[1], 1);
		bus(0, OFS_CTRL, 0);
		chk(r, 32'h4);
		$display("done two-wire");
		test_done;
	end
endmodule

// ===== include/scpc_eng_if.sv
// byte request and answer between the sequencer and a bit engine
// assumes all signals live on the core clock
`timescale 1ns/1ps
interface scpc_eng_if;
	logic go;
	logic [7:0] tx;
	logic ack_out;
	logic lsb;
	logic fast;
	logic din;
	scpc_pkg::scpc_cmd_e cmd;
	logic [7:0] rx;
	logic ack_in;
	logic done;
	modport seq (output go, tx, ack_out, lsb, fast, din, cmd,
		input rx, ack_in, done);
	modport eng (input go, tx, ack_out, lsb, fast, din, cmd,
		output rx, ack_in, done);
endinterface

// ===== include/scpc_pkg.sv
// constants, offsets and types for the serial control port host
// assumes a 250 MHz core clock; no module or clock of its own
package scpc_pkg;
	// core clock and link rates
	localparam int CLK_MHZ = 250;
	localparam int STD_KHZ = 100;
	localparam int FAST_KHZ = 400;
	// quarter bit times, rounded up so the bus never runs too fast
	localparam int STD_QTR = (CLK_MHZ * 1000 + 4 * STD_KHZ - 1) / (4 * STD_KHZ);
	localparam int FAST_QTR =
		(CLK_MHZ * 1000 + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
	// half period of the spi shift clock, in core cycles
	localparam int SPI_HALF = 4;
	// register offsets, byte addresses
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_ADDR = 5'h04;
	localparam logic [4:0] OFS_WDATA = 5'h08;
	localparam logic [4:0] OFS_RDATA = 5'h0c;
	localparam logic [4:0] OFS_STAT = 5'h10;
	localparam logic [4:0] OFS_PINS = 5'h14;
	// control fields
	localparam int CTL_GO = 0;
	localparam int CTL_RD = 1;
	localparam int CTL_I2C = 2;
	localparam int CTL_4W = 3;
	localparam int CTL_CNT = 4;
	localparam int CTL_FAST = 6;
	// device facts
	localparam logic [3:0] I2C_ADDR_HI = 4'h9;
	localparam logic [12:0] LSB_REG = 13'h0000;
	localparam int LSB_BIT = 6;
	localparam logic [12:0] ADDR_TOP = 13'h1fff;
	// byte engine commands
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_XFER} scpc_cmd_e;
endpackage

// ===== verilog/scpc_host.sv
// serial control port host: avalon-mm registers, spi and two-wire master
// assumes a single 250 MHz clock; pins are synchronised here
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module scpc_host import scpc_pkg::*; (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// spi pins
	output logic o_sclk,
	output logic o_cs_b,
	input wire logic i_sdio,
	output logic o_sdio,
	output logic o_sdio_oe,
	input wire logic i_serial_out_line,
	// two-wire pins, open drain
	output logic o_scl,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// strap levels for the device
	output logic [2:0] o_port_select_pins
);
	typedef enum {ST_IDLE, ST_SPI_IHI, ST_SPI_ILO, ST_SPI_DATA,
		ST_I2C_S, ST_I2C_DEV, ST_I2C_AHI, ST_I2C_ALO, ST_I2C_WR,
		ST_I2C_RS, ST_I2C_RDEV, ST_I2C_RD, ST_I2C_P} scpc_st_e;

	function automatic logic is_spi(input scpc_st_e s);
		return s == ST_SPI_IHI || s == ST_SPI_ILO || s == ST_SPI_DATA;
	endfunction

	function automatic logic [12:0] next_addr(input logic [12:0] a,
		input logic up);
		if (up)
			return (a == ADDR_TOP) ? a : a + 13'h1;
		return (a == 13'h0) ? a : a - 13'h1;
	endfunction

	scpc_st_e st_r, st_nxt;
	logic iss_r, iss_nxt, rd_r, rd_nxt, i2c_r, i2c_nxt, fourw_r, fourw_nxt;
	logic fast_r, fast_nxt, nack_r, nack_nxt, lsb_r, lsb_nxt;
	logic lsbv_r, lsbv_nxt, lsbset_r, lsbset_nxt;
	logic cs_b_r, cs_b_nxt, oe_r, oe_nxt, wait_r, wait_nxt;
	logic [1:0] idx_r, idx_nxt, cnt_r, cnt_nxt;
	logic [2:0] sel_r, sel_nxt, s1_r, s2_r;
	logic [12:0] cur_r, cur_nxt;
	logic [15:0] addr_r, addr_nxt, instr;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rdd_r, rdd_nxt;
	logic [7:0] eng_tx;
	logic eng_ack, done, nackst, scl_pull, sda_pull;

	scpc_eng_if spi_b();
	scpc_eng_if i2c_b();

	// pin synchronisers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= 3'h7;
			s2_r <= 3'h7;
		end else begin
			s1_r <= {i_sda, i_serial_out_line, i_sdio};
			s2_r <= s1_r;
		end
	end

	assign instr = {rd_r, cnt_r, cur_r};

	// byte to send in each state
	always_comb begin
		eng_tx = 8'hff;
		eng_ack = 1'b1;
		case (st_r)
		ST_SPI_IHI: eng_tx = lsb_r ? instr[7:0] : instr[15:8];
		ST_SPI_ILO: eng_tx = lsb_r ? instr[15:8] : instr[7:0];
		ST_SPI_DATA: eng_tx = wdata_r[{idx_r, 3'h0} +: 8];
		ST_I2C_DEV: eng_tx = {I2C_ADDR_HI, sel_r, 1'b0};
		ST_I2C_RDEV: eng_tx = {I2C_ADDR_HI, sel_r, 1'b1};
		ST_I2C_AHI: eng_tx = addr_r[15:8];
		ST_I2C_ALO: eng_tx = addr_r[7:0];
		ST_I2C_WR: eng_tx = wdata_r[{idx_r, 3'h0} +: 8];
		ST_I2C_RD: eng_ack = (idx_r == cnt_r);
		default: eng_tx = 8'hff;
		endcase
	end

	assign done = spi_b.done | i2c_b.done;
	assign nackst = st_r == ST_I2C_DEV || st_r == ST_I2C_AHI ||
		st_r == ST_I2C_ALO || st_r == ST_I2C_WR || st_r == ST_I2C_RDEV;

	always_comb begin
		st_nxt = st_r;
		iss_nxt = iss_r;
		rd_nxt = rd_r;
		i2c_nxt = i2c_r;
		fourw_nxt = fourw_r;
		fast_nxt = fast_r;
		nack_nxt = nack_r;
		lsb_nxt = lsb_r;
		lsbv_nxt = lsbv_r;
		lsbset_nxt = lsbset_r;
		idx_nxt = idx_r;
		cnt_nxt = cnt_r;
		sel_nxt = sel_r;
		cur_nxt = cur_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		rdd_nxt = rdd_r;
		wait_nxt = 1'b1;
		if ((i_avs_read || i_avs_write) && wait_r) begin
			wait_nxt = 1'b0;
			case (i_avs_address)
			OFS_CTRL: rdd_nxt = {25'h0, fast_r, cnt_r, fourw_r, i2c_r, rd_r, 1'b0};
			OFS_ADDR: rdd_nxt = {16'h0, addr_r};
			OFS_WDATA: rdd_nxt = wdata_r;
			OFS_RDATA: rdd_nxt = rdata_r;
			OFS_STAT: rdd_nxt = {29'h0, lsb_r, nack_r, st_r != ST_IDLE};
			OFS_PINS: rdd_nxt = {29'h0, sel_r};
			default: rdd_nxt = 32'h0;
			endcase
		end
		if (i_avs_write && !wait_r && st_r == ST_IDLE) begin
			case (i_avs_address)
			OFS_CTRL: begin
				rd_nxt = i_avs_writedata[CTL_RD];
				i2c_nxt = i_avs_writedata[CTL_I2C];
				fourw_nxt = i_avs_writedata[CTL_4W];
				cnt_nxt = i_avs_writedata[CTL_CNT +: 2];
				fast_nxt = i_avs_writedata[CTL_FAST];
				if (i_avs_writedata[CTL_GO]) begin
					st_nxt = i_avs_writedata[CTL_I2C] ? ST_I2C_S : ST_SPI_IHI;
					idx_nxt = 2'h0;
					nack_nxt = 1'b0;
					cur_nxt = addr_r[12:0];
				end
			end
			OFS_ADDR: addr_nxt = i_avs_writedata[15:0];
			OFS_WDATA: wdata_nxt = i_avs_writedata;
			OFS_PINS: sel_nxt = i_avs_writedata[2:0];
			default: ;
			endcase
		end
		if (st_r == ST_IDLE && lsbset_r) begin
			lsb_nxt = lsbv_r;
			lsbset_nxt = 1'b0;
		end
		if (st_r != ST_IDLE && !iss_r)
			iss_nxt = 1'b1;
		if (done) begin
			iss_nxt = 1'b0;
			case (st_r)
			ST_SPI_IHI: st_nxt = ST_SPI_ILO;
			ST_SPI_ILO: st_nxt = ST_SPI_DATA;
			ST_SPI_DATA: begin
				if (rd_r) begin
					rdata_nxt[{idx_r, 3'h0} +: 8] = spi_b.rx;
				end else if (cur_r == LSB_REG) begin
					lsbv_nxt = eng_tx[LSB_BIT];
					lsbset_nxt = 1'b1;
				end
				cur_nxt = next_addr(cur_r, lsb_r);
				idx_nxt = idx_r + 2'h1;
				if (idx_r == cnt_r)
					st_nxt = ST_IDLE;
			end
			ST_I2C_S: st_nxt = ST_I2C_DEV;
			ST_I2C_DEV: st_nxt = ST_I2C_AHI;
			ST_I2C_AHI: st_nxt = ST_I2C_ALO;
			ST_I2C_ALO: st_nxt = rd_r ? ST_I2C_RS : ST_I2C_WR;
			ST_I2C_WR, ST_I2C_RD: begin
				if (st_r == ST_I2C_RD)
					rdata_nxt[{idx_r, 3'h0} +: 8] = i2c_b.rx;
				idx_nxt = idx_r + 2'h1;
				if (idx_r == cnt_r)
					st_nxt = ST_I2C_P;
			end
			ST_I2C_RS: st_nxt = ST_I2C_RDEV;
			ST_I2C_RDEV: st_nxt = ST_I2C_RD;
			ST_I2C_P: st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
			endcase
			if (nackst && i2c_b.ack_in) begin
				nack_nxt = 1'b1;
				st_nxt = ST_I2C_P;
			end
		end
		cs_b_nxt = !is_spi(st_nxt);
		oe_nxt = is_spi(st_nxt) && !(st_nxt == ST_SPI_DATA && rd_nxt);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= ST_IDLE;
			iss_r <= 1'b0;
			rd_r <= 1'b0;
			i2c_r <= 1'b0;
			fourw_r <= 1'b0;
			fast_r <= 1'b0;
			nack_r <= 1'b0;
			lsb_r <= 1'b0;
			lsbv_r <= 1'b0;
			lsbset_r <= 1'b0;
			cs_b_r <= 1'b1;
			oe_r <= 1'b0;
			wait_r <= 1'b1;
			idx_r <= 2'h0;
			cnt_r <= 2'h0;
			sel_r <= 3'h0;
			cur_r <= 13'h0;
			addr_r <= 16'h0;
			wdata_r <= 32'h0;
			rdata_r <= 32'h0;
			rdd_r <= 32'h0;
		end else begin
			st_r <= st_nxt;
			iss_r <= iss_nxt;
			rd_r <= rd_nxt;
			i2c_r <= i2c_nxt;
			fourw_r <= fourw_nxt;
			fast_r <= fast_nxt;
			nack_r <= nack_nxt;
			lsb_r <= lsb_nxt;
			lsbv_r <= lsbv_nxt;
			lsbset_r <= lsbset_nxt;
			cs_b_r <= cs_b_nxt;
			oe_r <= oe_nxt;
			wait_r <= wait_nxt;
			idx_r <= idx_nxt;
			cnt_r <= cnt_nxt;
			sel_r <= sel_nxt;
			cur_r <= cur_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			rdd_r <= rdd_nxt;
		end
	end

	// engine hookup
	assign spi_b.go = is_spi(st_r) && !iss_r;
	assign spi_b.tx = eng_tx;
	assign spi_b.ack_out = 1'b1;
	assign spi_b.lsb = lsb_r;
	assign spi_b.fast = 1'b0;
	assign spi_b.din = fourw_r ? s2_r[1] : s2_r[0];
	assign spi_b.cmd = CMD_XFER;
	assign i2c_b.go = st_r != ST_IDLE && !is_spi(st_r) && !iss_r;
	assign i2c_b.tx = eng_tx;
	assign i2c_b.ack_out = eng_ack;
	assign i2c_b.lsb = 1'b0;
	assign i2c_b.fast = fast_r;
	assign i2c_b.din = s2_r[2];
	assign i2c_b.cmd = (st_r == ST_I2C_S || st_r == ST_I2C_RS) ? CMD_START :
		(st_r == ST_I2C_P) ? CMD_STOP : CMD_XFER;

	scpc_spi_byte #(.HALF(SPI_HALF)) u_spi (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.b(spi_b),
		.o_sclk(o_sclk),
		.o_mosi(o_sdio)
	);

	scpc_i2c_byte u_i2c (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.b(i2c_b),
		.o_scl_pull(scl_pull),
		.o_sda_pull(sda_pull)
	);

	assign o_avs_readdata = rdd_r;
	assign o_avs_waitrequest = wait_r;
	assign o_cs_b = cs_b_r;
	assign o_sdio_oe = oe_r;
	assign o_scl = 1'b0;
	assign o_scl_oe = scl_pull;
	assign o_sda = 1'b0;
	assign o_sda_oe = sda_pull;
	assign o_port_select_pins = sel_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_ack;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	property p_wait;
		((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> s_ack;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer not one cycle");
	property p_instr_first;
		($fell(cs_b_r) && !lsb_r) |-> ##[0:2] (spi_b.go && spi_b.tx[7] == rd_r);
	endproperty
	a_instr_first: assert property (p_instr_first)
		else $error("spi does not open with direction bit");
	property p_dev_addr;
		(st_r == ST_I2C_DEV && i2c_b.go)
			|-> i2c_b.tx == {I2C_ADDR_HI, o_port_select_pins, 1'b0};
	endproperty
	a_dev_addr: assert property (p_dev_addr)
		else $error("slave address byte wrong");
	property p_nack_stop;
		(nackst && i2c_b.done && i2c_b.ack_in) |=> (st_r == ST_I2C_P && nack_r);
	endproperty
	a_nack_stop: assert property (p_nack_stop)
		else $error("refusal not followed by stop");
	property p_spi_count;
		(st_r == ST_SPI_DATA && spi_b.done && idx_r == cnt_r)
			|=> (st_r == ST_IDLE && o_cs_b);
	endproperty
	a_spi_count: assert property (p_spi_count)
		else $error("spi byte count wrong");
endmodule

// ===== verilog/scpc_i2c_byte.sv
// two-wire bit engine: start, stop, or nine-bit byte with acknowledge
// assumes din is synchronised; the clock line is never stretched
`timescale 1ns/1ps
module scpc_i2c_byte import scpc_pkg::*; (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// byte requests
	scpc_eng_if.eng b,
	// open-drain pull-down enables
	output logic o_scl_pull,
	output logic o_sda_pull
);
	logic busy_r, busy_nxt, done_r, done_nxt;
	logic scl_r, scl_nxt, sda_r, sda_nxt;
	logic [1:0] q_r, q_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [8:0] sh_r, sh_nxt, rx_r, rx_nxt;
	logic [15:0] div_r, div_nxt, qlen;

	assign qlen = b.fast ? 16'(FAST_QTR - 1) : 16'(STD_QTR - 1);

	always_comb begin
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		scl_nxt = scl_r;
		sda_nxt = sda_r;
		q_nxt = q_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rx_nxt = rx_r;
		div_nxt = div_r;
		if (!busy_r && b.go) begin
			busy_nxt = 1'b1;
			q_nxt = 2'h0;
			bit_nxt = 4'h0;
			div_nxt = 16'h0;
			sh_nxt = {b.tx, b.ack_out};
		end else if (busy_r) begin
			if (div_r == qlen) begin
				div_nxt = 16'h0;
				q_nxt = q_r + 2'h1;
				case (b.cmd)
				CMD_START: begin
					case (q_r)
					2'h0: sda_nxt = 1'b0;
					2'h1: scl_nxt = 1'b0;
					2'h2: sda_nxt = 1'b1;
					default: scl_nxt = 1'b1;
					endcase
				end
				CMD_STOP: begin
					case (q_r)
					2'h0: sda_nxt = 1'b1;
					2'h1: scl_nxt = 1'b0;
					2'h2: sda_nxt = 1'b0;
					default: ;
					endcase
				end
				default: begin
					case (q_r)
					2'h0: sda_nxt = !sh_r[8];
					2'h1: scl_nxt = 1'b0;
					2'h2: rx_nxt = {rx_r[7:0], b.din};
					default: begin
						scl_nxt = 1'b1;
						sh_nxt = {sh_r[7:0], 1'b1};
						bit_nxt = bit_r + 4'h1;
					end
					endcase
				end
				endcase
				if (q_r == 2'h3 && (b.cmd != CMD_XFER || bit_r == 4'h8)) begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
			end else begin
				div_nxt = div_r + 16'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			scl_r <= 1'b0;
			sda_r <= 1'b0;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			sh_r <= 9'h1ff;
			rx_r <= 9'h0;
			div_r <= 16'h0;
		end else begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
			q_r <= q_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			rx_r <= rx_nxt;
			div_r <= div_nxt;
		end
	end

	assign o_scl_pull = scl_r;
	assign o_sda_pull = sda_r;
	assign b.rx = rx_r[8:1];
	assign b.ack_in = rx_r[0];
	assign b.done = done_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	property p_data_stable;
		(busy_r && b.cmd == CMD_XFER && !scl_r && !$past(scl_r))
			|-> $stable(sda_r);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data moved with clock high");
	property p_start_cond;
		(busy_r && b.cmd == CMD_START && $rose(sda_r)) |-> !scl_r;
	endproperty
	a_start_cond: assert property (p_start_cond)
		else $error("start not with clock high");
	property p_stop_cond;
		(busy_r && b.cmd == CMD_STOP && $fell(sda_r)) |-> !scl_r;
	endproperty
	a_stop_cond: assert property (p_stop_cond)
		else $error("stop not with clock high");
endmodule

// ===== verilog/scpc_spi_byte.sv
// spi byte shifter: eight shift clocks per request, mode 0
// assumes din is already synchronised to the core clock
`timescale 1ns/1ps
module scpc_spi_byte import scpc_pkg::*; #(
	parameter int HALF = SPI_HALF
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// byte requests
	scpc_eng_if.eng b,
	// pins
	output logic o_sclk,
	output logic o_mosi
);
	logic busy_r, busy_nxt, sclk_r, sclk_nxt, done_r, done_nxt;
	logic mosi_r, mosi_nxt;
	logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
	logic [3:0] step_r, step_nxt;
	logic [15:0] div_r, div_nxt;

	always_comb begin
		busy_nxt = busy_r;
		sclk_nxt = sclk_r;
		done_nxt = 1'b0;
		sh_nxt = sh_r;
		rx_nxt = rx_r;
		step_nxt = step_r;
		div_nxt = div_r;
		if (!busy_r && b.go) begin
			busy_nxt = 1'b1;
			div_nxt = 16'h0;
			step_nxt = 4'h0;
			sh_nxt = b.tx;
		end else if (busy_r) begin
			if (div_r == 16'(HALF - 1)) begin
				div_nxt = 16'h0;
				step_nxt = step_r + 4'h1;
				if (!step_r[0]) begin
					// rising edge: both ends sample here
					sclk_nxt = 1'b1;
					rx_nxt = b.lsb ? {b.din, rx_r[7:1]} : {rx_r[6:0], b.din};
				end else begin
					sclk_nxt = 1'b0;
					sh_nxt = b.lsb ? {1'b0, sh_r[7:1]} : {sh_r[6:0], 1'b0};
					if (step_r == 4'hf) begin
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
					end
				end
			end else begin
				div_nxt = div_r + 16'h1;
			end
		end
		mosi_nxt = b.lsb ? sh_nxt[0] : sh_nxt[7];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_r <= 1'b0;
			sclk_r <= 1'b0;
			done_r <= 1'b0;
			mosi_r <= 1'b0;
			sh_r <= 8'h0;
			rx_r <= 8'h0;
			step_r <= 4'h0;
			div_r <= 16'h0;
		end else begin
			busy_r <= busy_nxt;
			sclk_r <= sclk_nxt;
			done_r <= done_nxt;
			mosi_r <= mosi_nxt;
			sh_r <= sh_nxt;
			rx_r <= rx_nxt;
			step_r <= step_nxt;
			div_r <= div_nxt;
		end
	end

	assign o_sclk = sclk_r;
	assign o_mosi = mosi_r;
	assign b.rx = rx_r;
	assign b.ack_in = 1'b0;
	assign b.done = done_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	property p_sclk_half;
		$changed(sclk_r) |=> $stable(sclk_r)[*3];
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("sclk half short");
	property p_byte_len;
		(b.go && !busy_r) |-> ##65 done_r;
	endproperty
	a_byte_len: assert property (p_byte_len)
		else $error("spi byte not 64 cycles");
endmodule
